// *** tws_cfg.svh ***
// Constants for the two-wire master status and read-back block.
// Assumes APB byte addressing: the byte address of a register is four times its index.
//
// Summary of operation
// RULE1 - Done flag reads 1 when transfer finished
// RULE2 - Command register mirrors ack bit2, launch bit4
// RULE3 - Host writes data, command, then polls status
// RULE4 - Host reads command, lowlevel, status, readdata
// RULE5 - Read-data register returns same byte as data
// RULE6 - Received byte field read-only, reset zero
// RULE7 - Ack flag set on acknowledged write
// RULE8 - Launch clears done; final phase sets it
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define TWS_IDX_INT_STAT 8'hE0
`define TWS_IDX_INT_MASK 8'hE1
`define TWS_IDX_DATA 8'hEA
`define TWS_IDX_CMD 8'hEB
`define TWS_IDX_LOWLEVEL 8'hEC
`define TWS_IDX_STATUS 8'hED
`define TWS_IDX_READBACK 8'hEE

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TWS_CMD_READ_BIT 0
`define TWS_CMD_ACK_BIT 2
`define TWS_CMD_LAUNCH_BIT 4
`define TWS_STAT_DONE_BIT 0
`define TWS_STAT_ACK_BIT 1
`define TWS_INT_DONE_BIT 0
`define TWS_INT_NACK_BIT 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TWS_RX_RESET 8'h00
`define TWS_INT_RESET 2'h0

// ----------------------------------------------------------------
// Timing: quarter of a serial bit period
// ----------------------------------------------------------------
`define TWS_CLK_NS 40
`define TWS_QTR_NS 2500
`define TWS_QTR_CYC ((`TWS_QTR_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)

`endif

// *** tws_pkg.sv ***
// Types shared by the two-wire master status block.
// Assumes the constants header is included by the design file.
package tws_pkg;

    // ------------------------------------------------------------
    // Serial engine states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b0_0001,
        ST_START = 5'b0_0010,
        ST_BIT   = 5'b0_0100,
        ST_ACK   = 5'b0_1000,
        ST_STOP  = 5'b1_0000
    } tws_state_t;

endpackage : tws_pkg

// *** tws_master_status.sv ***
// Two-wire master byte engine with APB status, command and read-back registers.
// Assumes a 25 MHz clock, open-drain pads outside, and an APB master on the same clock.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "tws_cfg.svh"

module tws_master_status (
    input wire logic clock_i,          // Core clock, 25 MHz
    input wire logic reset_i,          // Synchronous reset, active high
    input wire logic psel_i,           // APB select
    input wire logic penable_i,        // APB access phase
    input wire logic pwrite_i,         // APB direction, 1 = write
    input wire logic [11:0] paddr_i,   // APB byte address
    input wire logic [31:0] pwdata_i,  // APB write data
    output logic [31:0] prdata_o,      // APB read data
    output logic pready_o,             // APB ready
    output logic pslverr_o,            // APB error on unmapped address
    output logic irq_o,                // Level interrupt
    input wire logic sda_i,            // Serial data pad level
    output logic sda_o,                // Serial data output value, always 0
    output logic sda_oe_o,             // Serial data pulled low while high
    output logic scl_o,                // Serial clock output value, always 0
    output logic scl_oe_o              // Serial clock pulled low while high
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    tws_pkg::tws_state_t state_reg;
    logic [6:0] tick_cnt_reg;
    logic [1:0] phase_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] tx_reg, rx_reg;
    logic read_mode_reg, done_reg, ack_reg;
    logic [1:0] int_stat_reg, int_stat_next, int_mask_reg;
    logic sda_s1_reg, sda_s2_reg, sda_s3_reg, sda_f_reg;
    logic sda_low_reg, scl_low_reg;
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg, irq_reg, zero_reg;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // Index sits in address bits 9:2; anything above must be zero
    wire [7:0] idx = paddr_i[9:2];
    wire hi_ok = (paddr_i[11:10] == 2'h0);
    wire sel_stat = hi_ok && (idx == `TWS_IDX_INT_STAT);
    wire sel_mask = hi_ok && (idx == `TWS_IDX_INT_MASK);
    wire sel_data = hi_ok && (idx == `TWS_IDX_DATA);
    wire sel_cmd = hi_ok && (idx == `TWS_IDX_CMD);
    wire sel_ll = hi_ok && (idx == `TWS_IDX_LOWLEVEL);
    wire sel_mis = hi_ok && (idx == `TWS_IDX_STATUS);
    wire sel_rb = hi_ok && (idx == `TWS_IDX_READBACK);
    wire mapped = sel_stat | sel_mask | sel_data | sel_cmd | sel_ll | sel_mis | sel_rb;
    wire setup = psel_i && !penable_i;
    wire access = psel_i && penable_i && pready_reg;
    wire wr_acc = access && pwrite_i && mapped;
    wire rd_acc = access && !pwrite_i;
    wire idle = (state_reg == tws_pkg::ST_IDLE);
    // Launch while busy is ignored so a running byte is never corrupted
    wire launch = wr_acc && sel_cmd && pwdata_i[`TWS_CMD_LAUNCH_BIT] && idle;

    // ------------------------------------------------------------
    // Read views
    // ------------------------------------------------------------
    wire [31:0] cmd_word = {27'h000_0000, !done_reg && !idle ? 1'b1 : !done_reg && launch,
                            1'b0, ack_reg, 1'b0, read_mode_reg}; // RULE2
    wire [31:0] mis_word = {30'h0000_0000, ack_reg, done_reg}; // RULE1 RULE7
    wire [31:0] data_word = {24'h00_0000, rx_reg}; // RULE6
    wire [31:0] rb_word = data_word; // RULE5
    wire [31:0] ll_word = {30'h0000_0000, sda_f_reg, !scl_low_reg};
    wire [31:0] rd_word =
        sel_stat ? {30'h0000_0000, int_stat_reg} :
        sel_mask ? {30'h0000_0000, int_mask_reg} :
        sel_data ? data_word :
        sel_cmd ? cmd_word :
        sel_ll ? ll_word :
        sel_mis ? mis_word :
        sel_rb ? rb_word : 32'h0000_0000;

    // ------------------------------------------------------------
    // Engine timing
    // ------------------------------------------------------------
    wire tick = (tick_cnt_reg == 7'(`TWS_QTR_CYC - 1));
    wire last_ph = tick && (phase_reg == 2'h3);
    wire finish = last_ph && (state_reg == tws_pkg::ST_STOP);
    wire ack_sample = tick && (phase_reg == 2'h2) && (state_reg == tws_pkg::ST_ACK);
    wire nack_event = ack_sample && !read_mode_reg && sda_f_reg;

    // ------------------------------------------------------------
    // Interrupt status: set beats a same-cycle write-one clear
    // ------------------------------------------------------------
    wire [1:0] int_set = {nack_event, finish};
    wire [1:0] int_clr = (wr_acc && sel_stat) ? pwdata_i[1:0] : 2'h0;
    assign int_stat_next = (int_stat_reg & ~int_clr) | int_set;
    wire [1:0] int_mask_next = (wr_acc && sel_mask) ? pwdata_i[1:0] : int_mask_reg;

    // ------------------------------------------------------------
    // APB answer: data latched in setup, ready on first access cycle
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg <= setup && !pwrite_i ? rd_word : prdata_reg;
            pready_reg <= setup;
            pslverr_reg <= setup && !mapped;
        end
    end

    // ------------------------------------------------------------
    // Interrupt and pad registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            int_stat_reg <= `TWS_INT_RESET;
            int_mask_reg <= `TWS_INT_RESET;
            irq_reg <= 1'b0;
            zero_reg <= 1'b0;
        end else begin
            int_stat_reg <= int_stat_next;
            int_mask_reg <= int_mask_next;
            irq_reg <= |(int_stat_next & int_mask_next);
            zero_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Data pad synchroniser; a change counts once stages 2 and 3 agree
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_s3_reg <= 1'b1;
            sda_f_reg <= 1'b1;
        end else begin
            sda_s1_reg <= sda_i;
            sda_s2_reg <= sda_s1_reg;
            sda_s3_reg <= sda_s2_reg;
            sda_f_reg <= (sda_s2_reg == sda_s3_reg) ? sda_s3_reg : sda_f_reg;
        end
    end

    // ------------------------------------------------------------
    // Quarter-bit timer and phase, idle holds them at zero
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (reset_i || idle) begin
            tick_cnt_reg <= 7'h00;
            phase_reg <= 2'h0;
        end else begin
            tick_cnt_reg <= tick ? 7'h00 : tick_cnt_reg + 7'h01;
            phase_reg <= tick ? phase_reg + 2'h1 : phase_reg;
        end
    end

    // ------------------------------------------------------------
    // Done and acknowledge flags
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            done_reg <= 1'b0;
            ack_reg <= 1'b0;
        end else begin
            if (launch) begin
                done_reg <= 1'b0; // RULE8
                ack_reg <= 1'b0;
            end else if (finish) begin
                done_reg <= 1'b1; // RULE1 RULE8
            end
            if (ack_sample) begin
                ack_reg <= !read_mode_reg && !sda_f_reg; // RULE7
            end
        end
    end

    // ------------------------------------------------------------
    // Byte engine: start, eight bits, acknowledge slot, stop
    // ------------------------------------------------------------
    // Reads always answer with a not-acknowledge: one byte per launch
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_reg <= tws_pkg::ST_IDLE;
            bit_cnt_reg <= 3'h0;
            tx_reg <= 8'h00;
            rx_reg <= `TWS_RX_RESET;
            read_mode_reg <= 1'b0;
            sda_low_reg <= 1'b0;
            scl_low_reg <= 1'b0;
        end else begin
            if (wr_acc && sel_data && idle) begin
                tx_reg <= pwdata_i[7:0];
            end
            unique case (state_reg)
                tws_pkg::ST_IDLE: begin
                    if (launch) begin
                        read_mode_reg <= pwdata_i[`TWS_CMD_READ_BIT];
                        bit_cnt_reg <= 3'h0;
                        state_reg <= tws_pkg::ST_START;
                    end
                end
                tws_pkg::ST_START: begin
                    if (tick && phase_reg == 2'h1) sda_low_reg <= 1'b1;
                    if (last_ph) begin
                        scl_low_reg <= 1'b1;
                        state_reg <= tws_pkg::ST_BIT;
                    end
                end
                tws_pkg::ST_BIT: begin
                    if (tick && phase_reg == 2'h0) begin
                        sda_low_reg <= !read_mode_reg && !tx_reg[3'h7 - bit_cnt_reg];
                    end
                    if (tick && phase_reg == 2'h1) scl_low_reg <= 1'b0;
                    if (tick && phase_reg == 2'h2 && read_mode_reg) begin
                        rx_reg <= {rx_reg[6:0], sda_f_reg}; // RULE6
                    end
                    if (last_ph) begin
                        scl_low_reg <= 1'b1;
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                        state_reg <= (bit_cnt_reg == 3'h7) ? tws_pkg::ST_ACK : tws_pkg::ST_BIT;
                    end
                end
                tws_pkg::ST_ACK: begin
                    if (tick && phase_reg == 2'h0) sda_low_reg <= 1'b0;
                    if (tick && phase_reg == 2'h1) scl_low_reg <= 1'b0;
                    if (last_ph) begin
                        scl_low_reg <= 1'b1;
                        state_reg <= tws_pkg::ST_STOP;
                    end
                end
                tws_pkg::ST_STOP: begin
                    if (tick && phase_reg == 2'h0) sda_low_reg <= 1'b1;
                    if (tick && phase_reg == 2'h1) scl_low_reg <= 1'b0;
                    if (tick && phase_reg == 2'h2) sda_low_reg <= 1'b0;
                    if (last_ph) begin
                        state_reg <= tws_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign irq_o = irq_reg;
    assign sda_o = zero_reg;
    assign scl_o = zero_reg;
    assign sda_oe_o = sda_low_reg;
    assign scl_oe_o = scl_low_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    AST_DONE_CLEARED_ON_LAUNCH: assert property (launch |=> !done_reg) // RULE8
        else $error("done flag not cleared by launch");
    AST_DONE_SET_AT_STOP: assert property (finish |=> done_reg && idle) // RULE8
        else $error("done flag not set after stop phase");
    AST_BUSY_NOT_DONE: assert property (!idle |-> !done_reg) // RULE1
        else $error("done flag high during transfer");
    AST_CMD_MIRROR: assert property (
        rd_acc && sel_cmd |-> prdata_o[`TWS_CMD_ACK_BIT] == $past(ack_reg)) // RULE2
        else $error("command ack bit differs from status");
    AST_CMD_BUSY_MIRROR: assert property (
        rd_acc && sel_cmd |-> prdata_o[`TWS_CMD_LAUNCH_BIT] == $past(!idle)) // RULE2
        else $error("command busy bit disagrees with engine state");
    AST_READBACK_EQ_DATA: assert property (
        rd_acc && sel_rb |-> prdata_o == {24'h00_0000, $past(rx_reg)}) // RULE5
        else $error("read-back differs from data register");
    AST_RX_ONLY_IN_BITS: assert property (
        !$stable(rx_reg) |-> $past(state_reg == tws_pkg::ST_BIT && read_mode_reg)) // RULE6
        else $error("received byte changed outside read bits");
    AST_ACK_ONLY_ON_WRITE: assert property (
        $rose(ack_reg) |-> $past(ack_sample && !read_mode_reg && !sda_f_reg)) // RULE7
        else $error("ack flag set without acknowledged write");
    AST_IRQ_LEVEL: assert property (irq_o == |(int_stat_reg & int_mask_reg))
        else $error("interrupt output disagrees with status and mask");

    COV_WRITE_DONE: cover property (finish && !read_mode_reg && ack_reg);
    COV_READ_DONE: cover property (finish && read_mode_reg);
    COV_NACK: cover property (nack_event);
    COV_SET_CLEAR_SAME: cover property (finish && int_clr[`TWS_INT_DONE_BIT]);

endmodule : tws_master_status

// *** tws_slave_model.sv ***
// Behavioural two-wire slave that faces the master status block.
// Assumes pull-ups on both lines; the bench resolves the open-drain levels.
`timescale 1ns/1ps

module tws_slave_model (
    input wire logic scl_i,            // Serial clock line level
    input wire logic sda_i,            // Serial data line level
    input wire logic read_mode_i,      // 1 = slave sends a byte
    input wire logic ack_en_i,         // 1 = acknowledge a written byte
    input wire logic [7:0] tx_byte_i,  // Byte sent on a read
    output logic sda_low_o,            // 1 = slave pulls data low
    output logic [7:0] rx_byte_o       // Byte taken on a write
);
    int cnt;
    logic active;

    // ------------------------------------------------------------
    // Framing: start and stop seen while the clock line is high
    // ------------------------------------------------------------
    initial begin
        cnt = 0;
        active = 1'b0;
        sda_low_o = 1'b0;
        rx_byte_o = 8'h00;
    end

    // Start opens a frame and restarts the slot count
    always @(negedge sda_i) begin
        if (scl_i === 1'b1) begin
            active = 1'b1;
            cnt = 0;
        end
    end

    // Stop closes the frame; data is released to the pull-up
    always @(posedge sda_i) begin
        if (scl_i === 1'b1) begin
            active = 1'b0;
            sda_low_o = 1'b0;
        end
    end

    // Written bits are taken MSB first on the rising clock
    always @(posedge scl_i) begin
        if (active && cnt >= 1 && cnt <= 8 && !read_mode_i) begin
            rx_byte_o = {rx_byte_o[6:0], sda_i};
        end
    end

    // Data only changes while the clock is low, so no false start or stop
    always @(negedge scl_i) begin
        if (active) begin
            cnt = cnt + 1;
            if (cnt <= 8) begin
                sda_low_o = read_mode_i & ~tx_byte_i[8 - cnt];
            end else if (cnt == 9) begin
                sda_low_o = ~read_mode_i & ack_en_i;
            end else begin
                sda_low_o = 1'b0;
            end
        end
    end
endmodule : tws_slave_model

// *** twowire_master_status_tb_top.sv ***
// Self-checking bench for the two-wire master status and read-back block.
// Assumes the slave model file and the constants header are compiled alongside.
`timescale 1ns/1ps
`include "tws_cfg.svh"

module twowire_master_status_tb_top;
    typedef struct {logic w; logic [7:0] idx; logic [31:0] wd; logic [31:0] exp; logic err;} tws_row_t;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq, sda_oe, scl_oe, slv_low, er, sda_out, scl_out;
    logic slv_rd = 1'b0;
    logic slv_ack = 1'b1;
    logic [7:0] slv_tx = 8'h00;
    logic [7:0] slv_rx;
    wire sda_line = ~(sda_oe | slv_low);
    wire scl_line = ~scl_oe;
    int num_errors = 0;
    int tests_run = 0;
    tws_row_t rows [12] = '{
        '{1'b0, `TWS_IDX_STATUS, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b0, `TWS_IDX_READBACK, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b0, `TWS_IDX_DATA, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b0, `TWS_IDX_CMD, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b0, `TWS_IDX_LOWLEVEL, 32'h0000_0000, 32'h0000_0003, 1'b0},
        '{1'b0, `TWS_IDX_INT_STAT, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b1, `TWS_IDX_INT_MASK, 32'h0000_0003, 32'h0000_0000, 1'b0},
        '{1'b0, `TWS_IDX_INT_MASK, 32'h0000_0000, 32'h0000_0003, 1'b0},
        '{1'b1, `TWS_IDX_READBACK, 32'h0000_00FF, 32'h0000_0000, 1'b0},
        '{1'b1, `TWS_IDX_STATUS, 32'h0000_0003, 32'h0000_0000, 1'b0},
        '{1'b0, `TWS_IDX_READBACK, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b0, 8'h10, 32'h0000_0000, 32'h0000_0000, 1'b1}};

    // ------------------------------------------------------------
    // Clock, design and far-side slave
    // ------------------------------------------------------------
    always #20 clock_i = ~clock_i;

    tws_master_status uut (.clock_i(clock_i), .reset_i(reset_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq),
        .sda_i(sda_line), .sda_o(sda_out), .sda_oe_o(sda_oe), .scl_o(scl_out),
        .scl_oe_o(scl_oe));

    tws_slave_model slave (.scl_i(scl_line), .sda_i(sda_line), .read_mode_i(slv_rd),
        .ack_en_i(slv_ack), .tx_byte_i(slv_tx), .sda_low_o(slv_low), .rx_byte_o(slv_rx));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task finish_test;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    // One APB transfer; request held until pready is seen high
    task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge clock_i);
        penable <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            finish_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Slave set up first, then data and command with the launch bit
    task launch(input logic [7:0] b, input logic r, input logic a);
        slv_tx = b;
        slv_rd = r;
        slv_ack = a;
        apb(1'b1, `TWS_IDX_DATA, {24'h00_0000, b});
        apb(1'b1, `TWS_IDX_CMD, {27'h000_0000, 1'b1, 3'h0, r});
    endtask : launch

    // Polling bounded by read count; a stuck flag ends the run as a failure
    task wait_done;
        int k;
        k = 0;
        do begin
            apb(1'b0, `TWS_IDX_STATUS, 32'h0000_0000);
            k++;
        end while (rd[0] !== 1'b1 && k < 2000);
        if (rd[0] !== 1'b1) begin
            num_errors++;
            finish_test();
        end
    endtask : wait_done

    task rdchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0000_0000);
        chk(what, rd, exp);
    endtask : rdchk

    task irqchk(input logic exp);
        repeat (2) @(posedge clock_i);
        chk("irq", {31'h0000_0000, irq}, {31'h0000_0000, exp});
    endtask : irqchk

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clock_i);
        reset_i <= 1'b0;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].idx, rows[i].wd);
            chk("pslverr", {31'h0000_0000, er}, {31'h0000_0000, rows[i].err});
            if (!rows[i].w) chk("reg", rd, rows[i].exp);
        end
        // Acknowledged write, done interrupt unmasked
        apb(1'b1, `TWS_IDX_INT_MASK, 32'h0000_0001);
        launch(8'hA5, 1'b0, 1'b1);
        rdchk("status busy", `TWS_IDX_STATUS, 32'h0000_0000);
        rdchk("cmd busy", `TWS_IDX_CMD, 32'h0000_0010);
        chk("pad values", {30'h0000_0000, sda_out, scl_out}, 32'h0000_0000);
        apb(1'b0, `TWS_IDX_LOWLEVEL, 32'h0000_0000);
        wait_done;
        chk("status ack", rd, 32'h0000_0003);
        rdchk("cmd ack", `TWS_IDX_CMD, 32'h0000_0004);
        chk("slave byte", {24'h00_0000, slv_rx}, 32'h0000_00A5);
        irqchk(1'b1);
        apb(1'b1, `TWS_IDX_INT_STAT, 32'h0000_0003);
        irqchk(1'b0);
        // Write refused by the slave
        launch(8'h5A, 1'b0, 1'b0);
        wait_done;
        chk("status nack", rd, 32'h0000_0001);
        rdchk("cmd nack", `TWS_IDX_CMD, 32'h0000_0000);
        // Read in host order: command, low-level, status, read-back
        apb(1'b1, `TWS_IDX_INT_MASK, 32'h0000_0000);
        apb(1'b1, `TWS_IDX_INT_STAT, 32'h0000_0003);
        launch(8'h3C, 1'b1, 1'b1);
        rdchk("cmd read", `TWS_IDX_CMD, 32'h0000_0011);
        apb(1'b0, `TWS_IDX_LOWLEVEL, 32'h0000_0000);
        wait_done;
        chk("status read", rd, 32'h0000_0001);
        rdchk("readback", `TWS_IDX_READBACK, 32'h0000_003C);
        rdchk("data", `TWS_IDX_DATA, 32'h0000_003C);
        irqchk(1'b0);
        apb(1'b1, `TWS_IDX_INT_MASK, 32'h0000_0001);
        irqchk(1'b1);
        apb(1'b1, `TWS_IDX_INT_STAT, 32'h0000_0001);
        irqchk(1'b0);
        // Reset in the middle of a transfer
        launch(8'hC3, 1'b0, 1'b1);
        repeat (100) @(posedge clock_i);
        reset_i <= 1'b1;
        repeat (5) @(posedge clock_i);
        reset_i <= 1'b0;
        rdchk("status reset", `TWS_IDX_STATUS, 32'h0000_0000);
        rdchk("readback reset", `TWS_IDX_READBACK, 32'h0000_0000);
        rdchk("cmd reset", `TWS_IDX_CMD, 32'h0000_0000);
        finish_test();
    end

    // Three full transfers of about 2800 cycles each, a fourth cut after 100 cycles, plus register traffic
    initial begin
        repeat (40000) @(posedge clock_i);
        num_errors++;
        finish_test();
    end
endmodule : twowire_master_status_tb_top
